// File: hdl/xid_regs.vh
`ifndef XID_REGS_VH
`define XID_REGS_VH

// ----------------------------------------------------------------
// instruction word fields
// ----------------------------------------------------------------
`define XID_IW_W 14
`define XID_LIT_OP_HI 13
`define XID_LIT_OP_LO 8
`define XID_LIT_OP 6'h3a
`define XID_FILE_OP_HI 13
`define XID_FILE_OP_LO 8
`define XID_FILE_OP 6'h06
`define XID_DEST_BIT 7
`define XID_ADDR_HI 6
`define XID_ADDR_LO 0
`define XID_LIT_HI 7
`define XID_LIT_LO 0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define XID_ACC_RST 8'h00
`define XID_ZERO_RST 1'b0
`define XID_BYTE_ZERO 8'h00
`define XID_ADDR_RST 7'h00
`define XID_PULSE_OFF 1'b0
`define XID_PULSE_ON 1'b1

`endif

// File: hdl/xid_xor_unit.v
`timescale 1ns/1ns
`include "xid_regs.vh"
module xid_xor_unit
(
  a,
  b,
  result,
  is_zero
);
  input wire [7:0] a;
  input wire [7:0] b;
  output wire [7:0] result;
  output wire is_zero;

  assign result = a ^ b;
  assign is_zero = (result == `XID_BYTE_ZERO);
endmodule

// File: hdl/xid_xor_datapath.v
`timescale 1ns/1ns
`include "xid_regs.vh"
module xid_xor_datapath
(
  ref_clk,
  rst,
  instr_valid,
  instr_word,
  file_rd_data,
  file_rd_addr,
  acc_r,
  zero_r,
  zero_we_r,
  file_we_r,
  file_wr_addr_r,
  file_wr_data_r,
  done_r
);
  input wire ref_clk;
  input wire rst;
  input wire instr_valid;
  input wire [13:0] instr_word;
  input wire [7:0] file_rd_data;
  output wire [6:0] file_rd_addr;
  output reg [7:0] acc_r;
  output reg zero_r;
  output reg zero_we_r;
  output reg file_we_r;
  output reg [6:0] file_wr_addr_r;
  output reg [7:0] file_wr_data_r;
  output reg done_r;

  // ----------------------------------------------------------------
  // operation classes, one-hot
  // ----------------------------------------------------------------
  // idle covers empty slots and every other opcode of the core
  localparam [2:0] OP_IDLE = 3'h1;
  localparam [2:0] OP_LIT = 3'h2;
  localparam [2:0] OP_FILE = 3'h4;

  // ----------------------------------------------------------------
  // instruction field helpers
  // ----------------------------------------------------------------
  // both xor forms keep their opcode in the same top bits
  function is_op;
    input [13:0] iw;
    input [5:0] op;
    begin
      is_op = (iw[`XID_LIT_OP_HI:`XID_LIT_OP_LO] == op);
    end
  endfunction

  function [2:0] op_class;
    input valid;
    input [13:0] iw;
    begin
      if (!valid)
        op_class = OP_IDLE;
      else if (is_op(iw, `XID_LIT_OP))
        op_class = OP_LIT;
      else if (is_op(iw, `XID_FILE_OP))
        op_class = OP_FILE;
      else
        op_class = OP_IDLE;
    end
  endfunction

  function [6:0] addr_field;
    input [13:0] iw;
    begin
      addr_field = iw[`XID_ADDR_HI:`XID_ADDR_LO];
    end
  endfunction

  function [7:0] lit_field;
    input [13:0] iw;
    begin
      lit_field = iw[`XID_LIT_HI:`XID_LIT_LO];
    end
  endfunction

  function dest_field;
    input [13:0] iw;
    begin
      dest_field = iw[`XID_DEST_BIT];
    end
  endfunction

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  wire [2:0] op_kind;
  wire xor_literal_to_acc;
  wire xor_acc_with_file;
  wire dest_file;
  wire file_wr_hit;
  wire [7:0] operand;
  wire [7:0] result;
  wire result_zero;
  reg [7:0] acc_nxt;
  reg zero_nxt;
  reg zero_we_nxt;
  reg file_we_nxt;
  reg [6:0] file_wr_addr_nxt;
  reg [7:0] file_wr_data_nxt;
  reg done_nxt;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // a word without its valid strobe is idle even if it decodes
  assign op_kind = op_class(instr_valid, instr_word);
  assign xor_literal_to_acc = (op_kind == OP_LIT);
  assign xor_acc_with_file = (op_kind == OP_FILE);
  assign dest_file = dest_field(instr_word);
  assign file_wr_hit = xor_acc_with_file && dest_file;
  // read address is combinational so the file data arrives same cycle
  assign file_rd_addr = addr_field(instr_word);
  // pick literal or file byte as second operand
  assign operand = xor_literal_to_acc ?
                   lit_field(instr_word) :
                   file_rd_data;

  // ----------------------------------------------------------------
  // xor unit
  // ----------------------------------------------------------------
  xid_xor_unit u_xor
  (
    .a(acc_r),
    .b(operand),
    .result(result),
    .is_zero(result_zero)
  );

  // ----------------------------------------------------------------
  // next values, one instruction per cycle
  // ----------------------------------------------------------------
  // write-back is registered: the decoder must forward a file byte
  // that the previous cycle wrote, this block does not
  always @*
  begin
    acc_nxt = acc_r;
    zero_nxt = zero_r;
    zero_we_nxt = `XID_PULSE_OFF;
    file_we_nxt = `XID_PULSE_OFF;
    file_wr_addr_nxt = file_wr_addr_r;
    file_wr_data_nxt = file_wr_data_r;
    done_nxt = `XID_PULSE_OFF;
    case (op_kind)
      OP_LIT:
      begin
        // no file strobe here, the literal form writes only the acc and the zero flag
        acc_nxt = result;
        zero_nxt = result_zero;
        zero_we_nxt = `XID_PULSE_ON;
        done_nxt = `XID_PULSE_ON;
      end
      OP_FILE:
      begin
        if (file_wr_hit)
        begin
          // accumulator kept as is
          file_we_nxt = `XID_PULSE_ON;
          file_wr_addr_nxt = file_rd_addr;
          file_wr_data_nxt = result;
        end
        else
        begin
          acc_nxt = result;
        end
        // zero flag follows the result whichever way it went
        zero_nxt = result_zero;
        zero_we_nxt = `XID_PULSE_ON;
        done_nxt = `XID_PULSE_ON;
      end
      OP_IDLE:
      begin
        // nothing moves; the zero flag keeps its last value
        acc_nxt = acc_r;
      end
      default:
      begin
        acc_nxt = acc_r;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      acc_r <= `XID_ACC_RST;
      zero_r <= `XID_ZERO_RST;
      zero_we_r <= `XID_PULSE_OFF;
      file_we_r <= `XID_PULSE_OFF;
      file_wr_addr_r <= `XID_ADDR_RST;
      file_wr_data_r <= `XID_BYTE_ZERO;
      done_r <= `XID_PULSE_OFF;
    end
    else
    begin
      acc_r <= acc_nxt;
      zero_r <= zero_nxt;
      zero_we_r <= zero_we_nxt;
      file_we_r <= file_we_nxt;
      file_wr_addr_r <= file_wr_addr_nxt;
      file_wr_data_r <= file_wr_data_nxt;
      done_r <= done_nxt;
    end
  end
endmodule

// File: tb/xid_file_model.sv
`timescale 1ns/1ns
module xid_file_model
(
  input wire ref_clk, we,
  input wire [6:0] wa, ra,
  input wire [7:0] wd,
  output wire [7:0] rd
);
  reg [7:0] mem [0:127];
  integer i;
  initial for (i = 0; i < 128; i = i + 1) mem[i] = i[7:0] ^ 8'h5a;
  always @(posedge ref_clk) if (we) mem[wa] <= wd;
  assign rd = mem[ra];
endmodule

// File: tb/xid_xor_datapath_sva.sv
`timescale 1ns/1ns
module xid_xor_datapath_sva
(
  input wire ref_clk,
  input wire rst,
  input wire instr_valid,
  input wire zero_r,
  input wire zero_we_r,
  input wire file_we_r,
  input wire done_r,
  input wire [13:0] instr_word,
  input wire [7:0] file_rd_data,
  input wire [7:0] acc_r,
  input wire [6:0] file_wr_addr_r,
  input wire [7:0] file_wr_data_r
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire [7:0] res = acc_r ^ file_rd_data;
  wire is_lit = instr_valid && instr_word[13:8] == 6'h3a;
  wire is_fil = instr_valid && instr_word[13:8] == 6'h06;
  sequence lit_s; is_lit; endsequence
  sequence fil_s; is_fil; endsequence
  a_lit_xor: assert property
    (lit_s |=>
      acc_r == $past(acc_r ^ instr_word[7:0]) && !file_we_r)
    else $error("bad literal xor");
  a_wr_addr: assert property
    (fil_s ##0 instr_word[7] |=> file_wr_addr_r == $past(instr_word[6:0]))
    else $error("bad file address");
  a_flag_strobe: assert property
    (zero_we_r == done_r) else $error("flag strobe apart from done");
  a_idle_quiet: assert property
    (!is_lit && !is_fil |=> !done_r && !zero_we_r && !file_we_r
      && $stable(acc_r) && $stable(zero_r))
    else $error("state moved without xor");
  a_file_acc: assert property
    (fil_s ##0 !instr_word[7] |=> acc_r == $past(res) && !file_we_r)
    else $error("bad xor to acc");
  a_file_wr: assert property
    (fil_s ##0 instr_word[7] |=> file_we_r && $stable(acc_r)
      && file_wr_data_r == $past(res)) else $error("bad file write");
  a_zero_flag: assert property
    (done_r |-> zero_r == ((file_we_r ? file_wr_data_r : acc_r) == 8'h00))
    else $error("bad zero flag");
endmodule
bind xid_xor_datapath xid_xor_datapath_sva i_sva (.*);

// File: tb/xid_xor_datapath_tb.sv
`timescale 1ns/1ns
module xid_xor_datapath_tb;
  reg ref_clk = 0, rst = 1, iv = 0;
  reg [13:0] iw = 14'h0000;
  wire [7:0] rd, acc, wd;
  wire [6:0] ra, wa;
  wire z, zwe, we, dn;
  reg [30:0] rows [0:7];
  reg [30:0] r;
  integer k, fails = 0, num_checks = 0;
  xid_xor_datapath i_xid_xor_datapath (.ref_clk(ref_clk), .rst(rst),
    .instr_valid(iv), .instr_word(iw), .file_rd_data(rd),
    .file_rd_addr(ra), .acc_r(acc), .zero_r(z), .zero_we_r(zwe),
    .file_we_r(we), .file_wr_addr_r(wa), .file_wr_data_r(wd), .done_r(dn));
  xid_file_model i_xid_file_model (.ref_clk(ref_clk), .we(we), .wa(wa),
    .ra(ra), .wd(wd), .rd(rd));
  initial forever #20 ref_clk = ~ref_clk;
  task chk(input ok);
  begin
    num_checks = num_checks + 1;
    if (!ok) fails = fails + 1;
    if (!ok) $display("Error %0t mismatch", $time);
  end
  endtask
  task give_verdict;
  begin
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  end
  endtask
  initial
  begin
    #100000 fails = fails + 1;
    give_verdict;
  end
  // a file write lands one edge late: no row rereads it next cycle
  initial
  begin
    rows[0] = {14'h3ab5, 8'hb5, 9'h000};
    rows[1] = {14'h3aaf, 8'h1a, 9'h000};
    rows[2] = {14'h3a1a, 8'h00, 9'h000};
    rows[3] = {14'h0685, 8'h00, 9'h15f};
    rows[4] = {14'h3aa0, 8'ha0, 9'h000};
    rows[5] = {14'h0605, 8'hff, 9'h000};
    rows[6] = {14'h0aff, 8'hff, 9'h000};
    rows[7] = {14'h06ff, 8'hff, 9'h1da};
    repeat (4) @(posedge ref_clk);
    #1 rst = 0;
    for (k = 0; k < 8; k = k + 1)
    begin
      r = rows[k];
      iw = r[30:17];
      iv = 1;
      @(posedge ref_clk) #1;
      chk(acc === r[16:9] && we === r[8]);
      if (r[8]) chk(wd === r[7:0] && wa === r[23:17]);
      chk(dn === (r[30:25] == 6'h3a || r[30:25] == 6'h06));
      chk(zwe === (r[30:25] == 6'h3a || r[30:25] == 6'h06));
      if (dn === 1)
        chk(z === ((r[8] ? r[7:0] : r[16:9]) == 8'h00));
    end
    $display("table done");
    iv = 0;
    @(posedge ref_clk) #1;
    chk(dn === 0 && zwe === 0 && acc === 8'hff && we === 0);
    $display("idle done");
    iw = 14'h3aff;
    iv = 1;
    @(posedge ref_clk) #1;
    chk(acc === 8'h00 && z === 1 && zwe === 1 && we === 0);
    iv = 0;
    @(posedge ref_clk) #1;
    chk(z === 1 && zwe === 0 && dn === 0 && acc === 8'h00);
    $display("hold done");
    rst = 1;
    #1 chk(acc === 8'h00 && z === 0 && zwe === 0 && dn === 0 && we === 0
      && wa === 7'h00 && wd === 8'h00);
    @(posedge ref_clk) #1 rst = 0;
    iw = 14'h3a5a;
    iv = 1;
    @(posedge ref_clk) #1;
    chk(acc === 8'h5a && z === 0 && dn === 1);
    $display("reset done");
    give_verdict;
  end
endmodule
